/* include/pcl_pkg.sv */
/*
  shared constants for the per-port control block: register offsets,
  field positions, reset values, timing figures and the management states.
  assumes a 20 MHz system clock and 16-bit management registers.
*/
package pcl_pkg;
  // management register offsets
  localparam logic [4:0] REG_BASIC = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_IND = 5'h18;
  localparam logic [4:0] REG_PORT = 5'h19;
  localparam logic [4:0] REG_DIAG = 5'h1B;
  // basic_control_reg field positions
  localparam int BC_LOOP = 14;
  localparam int BC_SPEED = 13;
  localparam int BC_NEG = 12;
  localparam int BC_ISO = 10;
  localparam int BC_DUP = 8;
  // port_status_reg field positions
  localparam int ST_LOOP = 3;
  localparam int ST_FULL = 2;
  localparam int ST_TEN = 1;
  localparam int ST_LINK = 0;
  // indicator_control_reg field positions
  localparam int IC_RXONLY = 8;
  localparam int IC_BLINK = 6;
  localparam int IC_DEN = 3;
  localparam int IC_DVAL = 0;
  // port_control_reg field positions
  localparam int PC_XAUTO = 15;
  localparam int PC_XFORCE = 14;
  localparam int PC_LEN = 11;
  localparam int PC_RUN = 9;
  localparam int PC_PASS = 8;
  localparam int PC_MODE = 5;
  // diag_control_reg field positions
  localparam int DC_CNT = 8;
  localparam int DC_CONT = 5;
  // reset values
  localparam logic XAUTO_RST = 1'b1;
  localparam logic [1:0] BLINK_RST = 2'h0;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  // timing
  localparam int CLK_KHZ = 20000;
  localparam int LINK_LOSS_MS = 50;
  localparam logic [2:0] NLP_LINK_COUNT = 3'h7;
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam int BLINK_W = 22;
  localparam int BURST_W = 10;
  // management frame opcodes
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  // management frame states
  typedef enum logic [1:0] {MS_PRE, MS_HDR, MS_TA, MS_DATA} pcl_mstate_t;
endpackage : pcl_pkg

/* include/pcl_packet_selftest_if.sv */
/*
  carrier between a port's register logic and its self-test engine.
  assumes both ends run on the block clock.
*/
`timescale 1ns/1ps
interface pcl_packet_selftest_if;
  logic run;          // engine transmitting
  logic cont;         // continuous transmit
  logic len15;        // 15-bit sequence
  logic clear;        // start/stop write pulse
  logic tx_en;        // generated enable
  logic [3:0] txd;    // generated nibble
  logic rx_dv;        // returning enable
  logic [3:0] rxd;    // returning nibble
  logic pass;         // pass status
  logic [7:0] errs;   // error count
  modport engine (input run, cont, len15, clear, rx_dv, rxd,
                  output tx_en, txd, pass, errs);
  modport ctrl (output run, cont, len15, clear, rx_dv, rxd,
                input tx_en, txd, pass, errs);
endinterface : pcl_packet_selftest_if

/* logic/pcl_prbs.sv */
/*
  pseudo-random self-test engine: nibble generator and self-synchronising
  checker with pass flag and saturating error count.
  assumes the returning nibble is on the block clock.
*/
`timescale 1ns/1ps
module pcl_prbs
  import pcl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // control side
  pcl_packet_selftest_if.engine bi
);
  logic [14:0] gen;        // generator state
  logic [14:0] hist;       // received history
  logic [14:0] next_gen;
  logic [14:0] next_hist;
  logic [3:0] gen_bits;    // four new bits
  logic [3:0] miss;        // miscompare per bit
  logic [3:0] fill;        // history fill count
  logic latched;           // miscompare held
  logic [BURST_W-1:0] burst;
  logic tx_go;             // nibble sent this cycle

  // four sequence steps per cycle on both sides
  always_comb begin
    next_gen = gen;
    next_hist = hist;
    gen_bits = 4'h0;
    miss = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      gen_bits[i] = bi.len15 ? next_gen[14] ^ next_gen[13] : next_gen[8] ^ next_gen[4];
      next_gen = {next_gen[13:0], gen_bits[i]};
      miss[i] = bi.rxd[i] ^ (bi.len15 ? next_hist[14] ^ next_hist[13]
                                     : next_hist[8] ^ next_hist[4]);
      next_hist = {next_hist[13:0], bi.rxd[i]};
    end
  end

  // transmit: continuous, or bursts with idle gaps
  assign tx_go = bi.run & (bi.cont | ~burst[BURST_W-1]);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gen <= PRBS_SEED;
      burst <= '0;
      bi.tx_en <= 1'b0;
      bi.txd <= 4'h0;
    end else if (clock_en) begin
      // step only for sent nibbles, so idle gaps do not break the sequence
      if (tx_go) begin
        gen <= next_gen;
      end
      burst <= burst + 1'b1;
      bi.tx_en <= tx_go;
      bi.txd <= gen_bits;
    end
  end

  // check: pass rises on good compare, miscompare latches until cleared
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hist <= '0;
      fill <= 4'h0;
      latched <= 1'b0;
      bi.pass <= 1'b0;
      bi.errs <= 8'h00;
    end else if (clock_en) begin
      if (bi.clear) begin
        latched <= 1'b0;
        bi.pass <= 1'b0;
        bi.errs <= 8'h00;
        fill <= 4'h0;
      end else if (bi.rx_dv) begin
        hist <= next_hist;
        if (fill != 4'hF) begin
          fill <= fill == 4'hC ? 4'hF : fill + 4'h4;
        end else if (|miss) begin
          latched <= 1'b1;
          bi.pass <= 1'b0;
          if (bi.errs != 8'hFF) begin
            bi.errs <= bi.errs + 8'h01;
          end
        end else if (!latched) begin
          bi.pass <= 1'b1;
        end
      end
    end
  end
endmodule : pcl_prbs

/* logic/pcl_top.sv */
/*
  two-port control logic: management slave, straps, crossover, isolate,
  loopback, carrier and collision, indicators and self-test per port.
  assumes mac and media data are on the block clock; mdc, mdio, signal
  detect and link pulses are asynchronous pins; straps are static.
*/
`timescale 1ns/1ps
module pcl_top
  import pcl_pkg::*;
#(
  parameter int LINK_LOSS_CYC = LINK_LOSS_MS * CLK_KHZ
)(
  // clock, reset, enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // straps
  input wire logic [3:0] addr_strap,
  input wire logic [1:0] fiber_mode_strap,
  input wire logic [1:0] xover_strap,
  input wire logic [1:0] crs_strap,
  input wire logic [1:0][2:0] ind_pin_in,
  // management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // negotiation results
  input wire logic [1:0] an_speed_100,
  input wire logic [1:0] an_full,
  input wire logic [1:0] an_swap,
  // media receive
  input wire logic [1:0] md_sig_det,
  input wire logic [1:0] md_nlp,
  input wire logic [1:0] md_rx_dv,
  input wire logic [1:0][3:0] md_rxd,
  // mac transmit
  input wire logic [1:0] mac_tx_en,
  input wire logic [1:0][3:0] mac_txd,
  // mac receive
  output logic [1:0] mac_rx_dv,
  output logic [1:0][3:0] mac_rxd,
  output logic [1:0] mac_crs,
  output logic [1:0] mac_col,
  output logic [1:0] mac_oe,
  // media transmit
  output logic [1:0] md_tx_en,
  output logic [1:0][3:0] md_txd,
  output logic [1:0] md_pair_swap,
  // indicators
  output logic [1:0][2:0] ind_out,
  output logic [1:0][2:0] ind_oe
);
  localparam int LOSS_W = $clog2(LINK_LOSS_CYC + 1);

  // pin synchronisers: {nlp, sig_det, mdio, mdc}
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_s3;
  logic [5:0] pin_f;        // filtered level
  logic [5:0] pin_fd;       // filtered, delayed
  logic [5:0] next_pin_f;
  logic mdc_rise;
  logic mdio_f;

  // strap capture
  logic strap_done;         // straps taken
  logic strap_take;         // first enabled cycle after reset
  logic [3:0] addr_lat;     // latched address straps

  // management frame
  pcl_mstate_t ms;
  logic [5:0] ones;         // preamble ones
  logic [3:0] cnt;          // bit counter
  logic [11:0] hdr;         // header shift
  logic [12:0] hdr_full;    // header with current bit
  logic hdr_hit;            // header addresses us
  logic hit;                // frame addresses us
  logic op_rd;              // frame is a read
  logic fr_port;            // addressed port
  logic [4:0] fr_reg;       // addressed register
  logic [15:0] sh;          // data shift
  logic wr_stb;             // register write pulse
  logic [15:0] wr_data;
  logic [1:0][15:0] rd_word;
  logic [15:0] rd_sel;
  logic [BLINK_W-1:0] blink_cnt; // free blink divider

  // three flops per pin, change counts when stages two and three agree
  assign next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
  assign mdc_rise = pin_f[0] & ~pin_fd[0];
  assign mdio_f = pin_f[1];

  // synchroniser chain
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_f <= '0;
      pin_fd <= '0;
    end else if (clock_en) begin
      pin_s1 <= {md_nlp, md_sig_det, mdio_in, mdc};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= next_pin_f;
      pin_fd <= pin_f;
    end
  end

  // straps taken once, on the first enabled edge after release
  assign strap_take = clock_en & ~strap_done;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strap_done <= 1'b0;
      addr_lat <= 4'h0;
    end else if (strap_take) begin
      strap_done <= 1'b1;
      addr_lat <= addr_strap;
    end
  end

  // header decode: start bit, opcode, address match
  assign hdr_full = {hdr, mdio_f};
  assign hdr_hit = hdr_full[12] & (hdr_full[11:10] == OP_READ | hdr_full[11:10] == OP_WRITE)
                   & (hdr_full[9:6] == addr_lat);
  assign wr_data = sh; // whole word once the last bit is in
  assign rd_sel = rd_word[fr_port];

  // management frame receiver and read driver
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ms <= MS_PRE;
      ones <= 6'h00;
      cnt <= 4'h0;
      hdr <= 12'h000;
      hit <= 1'b0;
      op_rd <= 1'b0;
      fr_port <= 1'b0;
      fr_reg <= 5'h00;
      sh <= 16'h0000;
      wr_stb <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (clock_en) begin
      wr_stb <= 1'b0;
      if (mdc_rise) begin
        case (ms)
          // count preamble ones, a zero after enough starts a frame
          MS_PRE: begin
            if (mdio_f) begin
              ones <= ones == PREAMBLE_ONES ? ones : ones + 6'h01;
            end else begin
              ms <= ones == PREAMBLE_ONES ? MS_HDR : MS_PRE;
              ones <= 6'h00;
              cnt <= 4'h0;
            end
          end
          // start bit, opcode, address, register
          MS_HDR: begin
            hdr <= hdr_full[11:0];
            cnt <= cnt + 4'h1;
            if (cnt == 4'hC) begin
              ms <= MS_TA;
              cnt <= 4'h0;
              hit <= hdr_hit;
              op_rd <= hdr_full[11:10] == OP_READ;
              fr_port <= hdr_full[5];
              fr_reg <= hdr_full[4:0];
            end
          end
          // turnaround: drive zero in its second bit on reads
          MS_TA: begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h0) begin
              mdio_oe <= hit & op_rd;
              mdio_out <= 1'b0;
            end else begin
              ms <= MS_DATA;
              cnt <= 4'h0;
              sh <= {rd_sel[14:0], 1'b0};
              mdio_out <= rd_sel[15];
            end
          end
          // sixteen data bits, msb first
          MS_DATA: begin
            sh <= {sh[14:0], mdio_f};
            mdio_out <= sh[15];
            cnt <= cnt + 4'h1;
            if (cnt == 4'hF) begin
              ms <= MS_PRE;
              mdio_oe <= 1'b0;
              wr_stb <= hit & ~op_rd;
            end
          end
          default: begin
            ms <= MS_PRE;
          end
        endcase
      end
    end
  end

  // shared divider for indicator blinking
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      blink_cnt <= '0;
    end else if (clock_en) begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  // one copy of everything below per port
  for (genvar p = 0; p < 2; p++) begin : g_port
    pcl_packet_selftest_if bi ();
    // basic_control_reg bits
    logic loop, speed, neg, iso, dup;
    // indicator_control_reg bits
    logic rx_only;
    logic [1:0] blink_rate;
    logic [2:0] den, dval;
    // port_control_reg and diag bits
    logic xauto, xforce, plen, run, cont;
    logic [1:0] mode;
    logic fib;                // fiber strapped
    logic [2:0] pol;          // indicator polarity
    // link detection
    logic [2:0] nlp_cnt;
    logic [LOSS_W-1:0] loss;
    logic link10;
    // derived
    logic wr_me, sp100, full, link, tx_ok, act, col_i, blink;
    logic m1, m2, rx_dv_i, src_en;
    logic [3:0] rxd_i, src_d;
    logic [2:0] ind_v, ind_f;
    logic [15:0] w_basic, w_stat, w_ind, w_port, w_diag;
    logic q_rx_dv, q_crs, q_col, q_oe, q_tx_en, q_swap;
    logic [3:0] q_rxd, q_txd;
    logic [2:0] q_ind, q_ioe;

    assign wr_me = wr_stb & fr_port == p;
    // operating speed and duplex
    assign sp100 = fib | (neg ? an_speed_100[p] : speed);
    assign full = neg ? an_full[p] : dup;
    assign link = sp100 ? pin_f[2+p] : link10;
    assign tx_ok = mac_tx_en[p] & ~iso;
    // transmit source, self-test takes the media side
    assign src_en = run ? bi.tx_en : tx_ok;
    assign src_d = run ? bi.txd : mac_txd[p];
    assign rx_dv_i = loop ? src_en : md_rx_dv[p];
    assign rxd_i = loop ? src_d : md_rxd[p];
    assign act = rx_dv_i | (~rx_only & tx_ok);
    assign col_i = ~full & ~loop & tx_ok & rx_dv_i;
    assign blink = blink_cnt[BLINK_W - 1 - 32'(blink_rate)];
    // mode decode: low bit set is mode one, both clear is mode two
    assign m1 = mode[0];
    assign m2 = ~mode[1] & ~mode[0];
    assign ind_v[0] = link & ~(~m1 & act & blink);
    assign ind_v[1] = sp100;
    assign ind_v[2] = m1 ? act : (m2 ? col_i : full);
    assign ind_f = (den & dval) | (~den & ind_v);
    assign bi.run = run;
    assign bi.cont = cont;
    assign bi.len15 = plen;
    assign bi.clear = wr_me & fr_reg == REG_PORT;
    assign bi.rx_dv = rx_dv_i;
    assign bi.rxd = rxd_i;

    // self-test engine
    pcl_prbs u_prbs (
      .clock(clock),
      .reset_n(reset_n),
      .clock_en(clock_en),
      .bi(bi)
    );

    // register words as read
    always_comb begin
      w_basic = 16'h0000;
      w_basic[BC_LOOP] = loop;
      w_basic[BC_SPEED] = speed;
      w_basic[BC_NEG] = neg;
      w_basic[BC_ISO] = iso;
      w_basic[BC_DUP] = dup;
      w_stat = 16'h0000;
      w_stat[ST_LOOP] = loop;
      w_stat[ST_FULL] = full;
      w_stat[ST_TEN] = ~sp100;
      w_stat[ST_LINK] = link;
      w_ind = 16'h0000;
      w_ind[IC_RXONLY] = rx_only;
      w_ind[IC_BLINK +: 2] = blink_rate;
      w_ind[IC_DEN +: 3] = den;
      w_ind[IC_DVAL +: 3] = dval;
      w_port = 16'h0000;
      w_port[PC_XAUTO] = xauto;
      w_port[PC_XFORCE] = xforce;
      w_port[PC_LEN] = plen;
      w_port[PC_RUN] = run;
      w_port[PC_PASS] = bi.pass;
      w_port[PC_MODE +: 2] = mode;
      w_port[4:0] = {addr_lat, 1'(p)};
      w_diag = 16'h0000;
      w_diag[DC_CNT +: 8] = bi.errs;
      w_diag[DC_CONT] = cont;
    end

    assign rd_word[p] = fr_reg == REG_BASIC ? w_basic :
                        fr_reg == REG_STATUS ? w_stat :
                        fr_reg == REG_IND ? w_ind :
                        fr_reg == REG_PORT ? w_port :
                        fr_reg == REG_DIAG ? w_diag : 16'h0000;

    // registers: strap presets once, then management writes
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        {loop, speed, neg, iso, dup} <= 5'h00;
        {rx_only, den, dval} <= 7'h00;
        blink_rate <= BLINK_RST;
        xauto <= XAUTO_RST;
        {xforce, plen, run, cont, fib} <= 5'h00;
        mode <= 2'h0;
        pol <= 3'h0;
      end else if (strap_take) begin
        fib <= fiber_mode_strap[p];
        neg <= ~fiber_mode_strap[p] & ind_pin_in[p][2];
        speed <= ind_pin_in[p][1];
        dup <= ind_pin_in[p][0];
        xauto <= xover_strap[p];
        mode <= {1'b0, crs_strap[p]};
        pol <= ind_pin_in[p];
      end else if (clock_en && wr_me) begin
        case (fr_reg)
          REG_BASIC: begin
            loop <= wr_data[BC_LOOP];
            speed <= wr_data[BC_SPEED];
            neg <= wr_data[BC_NEG] & ~fib;
            iso <= wr_data[BC_ISO];
            dup <= wr_data[BC_DUP];
          end
          REG_IND: begin
            rx_only <= wr_data[IC_RXONLY];
            blink_rate <= wr_data[IC_BLINK +: 2];
            den <= wr_data[IC_DEN +: 3];
            dval <= wr_data[IC_DVAL +: 3];
          end
          REG_PORT: begin
            xauto <= wr_data[PC_XAUTO];
            xforce <= wr_data[PC_XFORCE];
            plen <= wr_data[PC_LEN];
            run <= wr_data[PC_RUN];
            mode <= wr_data[PC_MODE +: 2];
          end
          REG_DIAG: begin
            cont <= wr_data[DC_CONT];
          end
          default: begin
            cont <= cont;
          end
        endcase
      end
    end

    // 10 Mb/s link: seven pulses or a packet, dropped by loss timer
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        nlp_cnt <= 3'h0;
        loss <= '0;
        link10 <= 1'b0;
      end else if (clock_en) begin
        if (pin_f[4+p] & ~pin_fd[4+p]) begin
          loss <= '0;
          nlp_cnt <= nlp_cnt == NLP_LINK_COUNT ? nlp_cnt : nlp_cnt + 3'h1;
          link10 <= link10 | (nlp_cnt + 3'h1 == NLP_LINK_COUNT);
        end else if (md_rx_dv[p]) begin
          loss <= '0;
          link10 <= 1'b1;
        end else if (loss == LOSS_W'(LINK_LOSS_CYC)) begin
          nlp_cnt <= 3'h0;
          link10 <= 1'b0;
        end else begin
          loss <= loss + 1'b1;
        end
      end
    end

    // mac, media and indicator outputs, all registered
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        {q_rx_dv, q_crs, q_col, q_oe, q_tx_en, q_swap} <= 6'h00;
        q_rxd <= 4'h0;
        q_txd <= 4'h0;
        q_ind <= 3'h0;
        q_ioe <= 3'h0;
      end else if (clock_en) begin
        q_rx_dv <= rx_dv_i;
        q_rxd <= rxd_i;
        q_crs <= rx_dv_i | (~full & tx_ok);
        q_col <= col_i;
        q_oe <= ~iso;
        // looped: no data, media keeps sending idle; isolated: no mac data, but a running self-test still sends
        q_tx_en <= ~loop & src_en;
        q_txd <= src_d;
        q_swap <= xforce | (xauto & neg & an_swap[p]);
        q_ind <= ind_f ^ pol;
        q_ioe <= {3{strap_done}};
      end
    end

    assign mac_rx_dv[p] = q_rx_dv;
    assign mac_rxd[p] = q_rxd;
    assign mac_crs[p] = q_crs;
    assign mac_col[p] = q_col;
    assign mac_oe[p] = q_oe;
    assign md_tx_en[p] = q_tx_en;
    assign md_txd[p] = q_txd;
    assign md_pair_swap[p] = q_swap;
    assign ind_out[p] = q_ind;
    assign ind_oe[p] = q_ioe;
  end
endmodule : pcl_top

/* bench/pcl_asserts.sv */
/* port-level checks of pcl_top, port a.
   assumes port a keeps mode 1, negotiation on and no direct control. */
`timescale 1ns/1ps
module pcl_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // watched pins
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic [1:0] an_speed_100,
  input wire logic [1:0] md_sig_det,
  input wire logic [1:0] md_rx_dv,
  input wire logic [1:0] mac_tx_en,
  input wire logic [1:0] mac_rx_dv,
  input wire logic [1:0] mac_crs,
  input wire logic [1:0] mac_col,
  input wire logic [1:0] mac_oe,
  input wire logic [1:0] md_tx_en,
  input wire logic [1:0][2:0] ind_pin_in,
  input wire logic [1:0][2:0] ind_out,
  input wire logic [1:0][2:0] ind_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // settled speed and link inputs
  sequence s_speed_held;
    (ind_oe[0][1] && $stable(an_speed_100[0])) [*6];
  endsequence
  sequence s_link_up;
    (ind_oe[0][0] && md_sig_det[0] && an_speed_100[0]) [*6];
  endsequence
  property p_ta;
    $rose(mdio_oe) |-> !mdio_out;
  endproperty
  property p_iso;
    !mac_oe[0] && $past(!mac_oe[0]) |-> !md_tx_en[0];
  endproperty
  property p_tx;
    md_tx_en[0] |-> $past(mac_tx_en[0]);
  endproperty
  property p_col;
    mac_col[0] |-> $past(mac_tx_en[0] && md_rx_dv[0]);
  endproperty
  property p_crs;
    mac_crs[0] |-> $past(mac_tx_en[0] || md_rx_dv[0]);
  endproperty
  property p_rx;
    mac_rx_dv[0] |-> $past(md_rx_dv[0] || mac_tx_en[0]);
  endproperty
  property p_speed;
    s_speed_held |-> ind_out[0][1] == (an_speed_100[0] ^ ind_pin_in[0][1]);
  endproperty
  property p_link;
    s_link_up |-> ind_out[0][0] != ind_pin_in[0][0];
  endproperty
  a_ta: assert property (p_ta) else $error("turnaround bit not low");
  a_iso: assert property (p_iso) else $error("isolated port sent data");
  a_tx: assert property (p_tx) else $error("media data without cause");
  a_col: assert property (p_col) else $error("collision without cause");
  a_crs: assert property (p_crs) else $error("carrier without cause");
  a_rx: assert property (p_rx) else $error("receive valid without cause");
  a_speed: assert property (p_speed) else $error("speed indicator wrong");
  a_link: assert property (p_link) else $error("link indicator off");
endmodule : pcl_asserts

/* bench/pcl_station.sv */
/* management station model driving mdc and a pulled-up mdio wire.
   assumes a 20 MHz bench clock. */
`timescale 1ns/1ps
module pcl_station
  import pcl_pkg::*;
(
  // clock
  input wire logic clock,
  // device side
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // station side
  output logic mdc,
  output logic mdio_in
);
  logic drv = 1'h0; // station owns the wire
  logic bit_v = 1'h1; // bit on the wire
  // released wire falls back to the pull-up
  assign mdio_in = mdio_oe ? mdio_out : (drv ? bit_v : 1'h1);
  initial mdc = 1'h0;
  // one whole frame, 12-clock bit cells
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'h1, rd ? OP_READ : OP_WRITE, pa, ra, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      mdc = 1'h0;
      drv = !(rd && i < 18);
      bit_v = f[i];
      repeat (6) @(negedge clock);
      if (i < 16) q[i] = mdio_in;
      mdc = 1'h1;
      repeat (6) @(negedge clock);
    end
    drv = 1'h0;
  endtask : frame
endmodule : pcl_station

/* bench/pcl_top_tb_top.sv */
/* bench top for pcl_top: straps, station, mac drive, port b media loop.
   assumes station and checker are compiled first. */
`timescale 1ns/1ps
module pcl_top_tb_top;
  import pcl_pkg::*;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic mdc, mdio_in, mdio_out, mdio_oe;
  logic rx_dv0 = 1'h0; // port a media receive
  logic [1:0] tx_en = 2'h0;
  logic [1:0] full = 2'h0;
  logic cen = 1'h1;
  logic [1:0] spd = 2'h3; // negotiated 100 Mb/s
  logic [1:0] swp = 2'h0;
  logic [1:0] sdet = 2'h3;
  logic [1:0] nlp = 2'h0;
  logic [3:0] err_mask = 4'h0; // corrupts port b loop
  logic [1:0] mac_rx_dv, mac_crs, mac_col, mac_oe, md_tx_en, md_pair_swap;
  logic [1:0][3:0] mac_rxd, md_txd;
  logic [1:0][2:0] ind_out, ind_oe;
  logic [15:0] q;
  int fails = 0;
  int compares = 0;
  int n;
  initial begin
    forever #25 clock = ~clock;
  end
  pcl_station st_u (.clock(clock), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_in(mdio_in));
  pcl_top #(.LINK_LOSS_CYC(200)) dut_u (.clock(clock), .reset_n(reset_n), .clock_en(cen),
    .addr_strap(4'h5), .fiber_mode_strap(2'h0), .xover_strap(2'h3), .crs_strap(2'h1),
    .ind_pin_in({3'h5, 3'h4}), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .an_speed_100(spd), .an_full(full), .an_swap(swp),
    .md_sig_det(sdet), .md_nlp(nlp), .md_rx_dv({md_tx_en[1], rx_dv0}),
    .md_rxd({md_txd[1] ^ err_mask, 4'h3}), .mac_tx_en(tx_en), .mac_txd({4'h0, 4'hA}),
    .mac_rx_dv(mac_rx_dv), .mac_rxd(mac_rxd), .mac_crs(mac_crs), .mac_col(mac_col),
    .mac_oe(mac_oe), .md_tx_en(md_tx_en), .md_txd(md_txd), .md_pair_swap(md_pair_swap),
    .ind_out(ind_out), .ind_oe(ind_oe));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] v);
    logic [15:0] d;
    st_u.frame(1'h0, pa, ra, v, d);
    repeat (4) @(negedge clock);
  endtask : wr
  task automatic rd_chk(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] m,
                        input logic [15:0] e);
    st_u.frame(1'h1, pa, ra, 16'h0000, q);
    check("register", q & m, e);
  endtask : rd_chk
  // one port a mac cycle, checked one clock later
  task automatic mac(input logic [1:0] act, input logic [7:0] m, input logic [7:0] w);
    tx_en[0] = act[1];
    rx_dv0 = act[0];
    @(negedge clock);
    check("mac", {8'h00, {mac_rxd[0], md_tx_en[0], mac_rx_dv[0], mac_crs[0], mac_col[0]} & m},
      {8'h00, w});
    tx_en[0] = 1'h0;
    rx_dv0 = 1'h0;
    @(negedge clock);
  endtask : mac
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(negedge clock);
    reset_n = 1'h1;
    repeat (4) @(negedge clock);
    rd_chk(5'h0A, REG_PORT, 16'hC17F, 16'h802A);
    rd_chk(5'h0B, REG_PORT, 16'hC17F, 16'h800B);
    rd_chk(5'h1C, REG_PORT, 16'hFFFF, 16'hFFFF);
    rd_chk(5'h0A, 5'h05, 16'hFFFF, 16'h0000);
    $display("straps test done");
    for (int d = 0; d < 2; d++) begin
      full[0] = d[0];
      repeat (4) @(negedge clock);
      mac(2'h2, 8'h0F, d ? 8'h08 : 8'h0A);
      mac(2'h3, 8'hFF, d ? 8'h3E : 8'h3F);
    end
    cen = 1'h0;
    mac(2'h2, 8'h0F, 8'h00);
    cen = 1'h1;
    wr(5'h0A, REG_BASIC, 16'h5000);
    rd_chk(5'h0A, REG_STATUS, 16'h0008, 16'h0008);
    mac(2'h2, 8'hFC, 8'hA4);
    wr(5'h0A, REG_BASIC, 16'h1400);
    mac(2'h2, 8'h08, 8'h00);
    check("mac enable", {15'h0000, mac_oe[0]}, 16'h0000);
    rd_chk(5'h0A, REG_BASIC, 16'h5500, 16'h1400);
    wr(5'h0A, REG_BASIC, 16'h1000);
    $display("mac test done");
    wr(5'h0A, REG_PORT, 16'h4020);
    check("swap", {15'h0000, md_pair_swap[0]}, 16'h0001);
    swp = 2'h1;
    wr(5'h0A, REG_PORT, 16'h0020);
    check("swap", {15'h0000, md_pair_swap[0]}, 16'h0000);
    wr(5'h0A, REG_PORT, 16'h8020);
    check("swap", {15'h0000, md_pair_swap[0]}, 16'h0001);
    wr(5'h0B, REG_IND, 16'h002B);
    rd_chk(5'h0B, REG_IND, 16'h01FF, 16'h002B);
    check("indicators", {13'h0000, ind_out[1]}, 16'h0006);
    sdet = 2'h2;
    repeat (6) @(negedge clock);
    check("link", {15'h0000, ind_out[0][0]}, 16'h0000);
    spd = 2'h2;
    for (n = 0; n < 14; n++) begin
      nlp[0] = !n[0];
      repeat (4) @(negedge clock);
      if (n == 11) check("link", {15'h0000, ind_out[0][0]}, 16'h0000);
    end
    check("link", {15'h0000, ind_out[0][0]}, 16'h0001);
    repeat (210) @(negedge clock);
    check("link", {15'h0000, ind_out[0][0]}, 16'h0000);
    {spd, sdet} = 4'hF;
    $display("control test done");
    wr(5'h0B, REG_DIAG, 16'h0020);
    wr(5'h0B, REG_PORT, 16'h0200);
    repeat (100) @(negedge clock);
    for (n = 0; n < 2000 && md_tx_en[1] !== 1'h1; n++) @(negedge clock);
    if (n == 2000) begin
      fails++;
      print_verdict();
    end
    err_mask = 4'h1;
    @(negedge clock);
    err_mask = 4'h0;
    rd_chk(5'h0B, REG_PORT, 16'h0100, 16'h0000);
    st_u.frame(1'h1, 5'h0B, REG_DIAG, 16'h0000, q);
    check("error count", {15'h0000, q[15:8] != 8'h00}, 16'h0001);
    check("continuous", {15'h0000, q[5]}, 16'h0001);
    wr(5'h0B, REG_DIAG, 16'h0000);
    for (int l = 0; l < 2; l++) begin
      wr(5'h0B, REG_PORT, l ? 16'h0A00 : 16'h0200);
      repeat (1500) @(negedge clock);
      rd_chk(5'h0B, REG_PORT, 16'h0100, 16'h0100);
      rd_chk(5'h0B, REG_DIAG, 16'hFF00, 16'h0000);
    end
    $display("selftest test done");
    print_verdict();
  end
endmodule : pcl_top_tb_top
bind pcl_top pcl_asserts chk_u (.clock, .reset_n, .mdio_out, .mdio_oe, .an_speed_100,
  .md_sig_det, .md_rx_dv, .mac_tx_en, .mac_rx_dv, .mac_crs, .mac_col, .mac_oe, .md_tx_en,
  .ind_pin_in, .ind_out, .ind_oe);
